// ---- hw/pulse_gen_pkg.sv ----
// Purpose: Shared constants and types for the pulse modulation generator
// Assumes: 40 MHz generator clock, plain register port
// Notes: Timing registers hold counts of clock cycles
`default_nettype none
package pulse_gen_pkg;
    localparam int CNT_W = 24;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TRAIN_DEPTH = 16;
    localparam int TRAIN_AW = 4;
    localparam int REP_W = 8;
    localparam int TRIG_LAT = 2;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SYNC_TIME_NS = 50;
    localparam int SYNC_CYC = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h04;
    localparam logic [ADDR_W-1:0] REG_WIDTH = 8'h08;
    localparam logic [ADDR_W-1:0] REG_DELAY = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_DWIDTH = 8'h10;
    localparam logic [ADDR_W-1:0] REG_DDELAY = 8'h14;
    localparam logic [ADDR_W-1:0] REG_CMD = 8'h18;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_TR_SEL = 8'h20;
    localparam logic [ADDR_W-1:0] REG_TR_ON = 8'h24;
    localparam logic [ADDR_W-1:0] REG_TR_OFF = 8'h28;
    localparam logic [ADDR_W-1:0] REG_TR_REP = 8'h2c;
    localparam logic [ADDR_W-1:0] REG_TR_LEN = 8'h30;
    // CTRL field positions
    localparam int F_MODE = 0;
    localparam int F_TRIG = 2;
    localparam int F_OUTEN = 5;
    localparam int F_OPOL = 6;
    localparam int F_TPOL = 7;
    localparam int F_RUN = 8;
    localparam int F_SYNCM = 9;
    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CMD_TRIG_BIT = 32'h0000_0001;

    typedef enum logic [1:0] {
        PM_SINGLE = 2'h0,
        PM_DOUBLE = 2'h1,
        PM_TRAIN = 2'h2
    } pmode_t;

    typedef enum logic [2:0] {
        TM_AUTO = 3'h0,
        TM_INT_SINGLE = 3'h1,
        TM_EXT_SINGLE = 3'h2,
        TM_EXT_RETRIG = 3'h3,
        TM_EXT_GATED = 3'h4
    } tmode_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LAT = 5'b00010,
        ST_DELAY = 5'b00100,
        ST_ON = 5'b01000,
        ST_OFF = 5'b10000
    } gstate_t;

    typedef struct packed {
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] width;
        logic [CNT_W-1:0] delay;
        logic [CNT_W-1:0] dwidth;
        logic [CNT_W-1:0] ddelay;
    } timing_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage
`default_nettype wire

// ---- hw/pulse_mod_function.sv ----
// Purpose: Internal pulse generator with single, double and train modes
// Assumes: One 40 MHz clock; ext trigger is asynchronous to it
// Notes: Timing values are cycle counts; software keeps width below period
//
// The plain strobed port and the register addresses are this design's own decisions.
`default_nettype none
module pulse_mod_function
    import pulse_gen_pkg::*;
#(
    parameter int DEPTH = TRAIN_DEPTH
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic ext_trig_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic pulse_o,
    output logic pulse_oe_o,
    output logic sync_o
);
    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        timing_t cfg;
        timing_t act;
        logic [TRAIN_AW-1:0] tr_sel;
        logic [TRAIN_AW:0] tr_len;
        gstate_t st;
        logic [CNT_W-1:0] per_cnt;
        logic [CNT_W-1:0] ph_cnt;
        logic [CNT_W-1:0] lat_cnt;
        logic second;
        logic [TRAIN_AW-1:0] tr_idx;
        logic [REP_W-1:0] tr_rep;
        logic [1:0] sync_cnt;
        logic sync_lvl;
        logic [1:0] trig_sync;
        logic trig_prev;
        logic sw_trig;
        logic pulse;
        logic pulse_oe;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t r;
    state_t n;
    logic [CNT_W-1:0] tr_on [DEPTH];
    logic [CNT_W-1:0] tr_off [DEPTH];
    logic [REP_W-1:0] tr_rp [DEPTH];
    bus_req_t req;

    pmode_t pm;
    tmode_t tm;
    logic trig_lvl;
    logic ext_evt;
    logic gate_on;
    logic start;
    logic busy;
    logic free_run;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign pm = pmode_t'(r.ctrl[F_MODE +: 2]);
    assign tm = tmode_t'(r.ctrl[F_TRIG +: 3]);
    // Inverted polarity makes the falling edge and low level active
    assign trig_lvl = r.trig_sync[1] ^ r.ctrl[F_TPOL];
    assign ext_evt = trig_lvl & ~r.trig_prev;
    assign gate_on = trig_lvl;
    assign busy = (r.st != ST_IDLE);
    assign free_run = r.ctrl[F_RUN] && (tm == TM_AUTO || (tm == TM_EXT_GATED && gate_on));

    always_comb
    begin
        start = 1'b0;
        if (r.ctrl[F_RUN])
        begin
            case (tm)
                TM_AUTO: start = !busy;
                TM_INT_SINGLE: start = r.sw_trig && !busy;
                TM_EXT_SINGLE: start = ext_evt && !busy;
                // Double mode lets the running pair finish first
                TM_EXT_RETRIG: start = ext_evt && !(busy && pm == PM_DOUBLE);
                TM_EXT_GATED: start = gate_on && !busy;
                default: start = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        n = r;
        n.trig_sync = {r.trig_sync[0], ext_trig_i};
        n.trig_prev = trig_lvl;
        n.sw_trig = 1'b0;
        n.rdata = '0;
        if (req.wr)
        begin
            case (req.addr)
                REG_CTRL: n.ctrl = req.wdata;
                REG_PERIOD: n.cfg.period = req.wdata[CNT_W-1:0];
                REG_WIDTH: n.cfg.width = req.wdata[CNT_W-1:0];
                REG_DELAY: n.cfg.delay = req.wdata[CNT_W-1:0];
                REG_DWIDTH: n.cfg.dwidth = req.wdata[CNT_W-1:0];
                REG_DDELAY: n.cfg.ddelay = req.wdata[CNT_W-1:0];
                // Ignored outside internal single so a stray write cannot fire later
                REG_CMD: n.sw_trig = |(req.wdata & CMD_TRIG_BIT) && tm == TM_INT_SINGLE;
                REG_TR_SEL: n.tr_sel = req.wdata[TRAIN_AW-1:0];
                REG_TR_LEN: n.tr_len = req.wdata[TRAIN_AW:0];
                default: ;
            endcase
        end
        if (req.rd)
        begin
            case (req.addr)
                REG_CTRL: n.rdata = r.ctrl;
                REG_PERIOD: n.rdata = DATA_W'(r.cfg.period);
                REG_WIDTH: n.rdata = DATA_W'(r.cfg.width);
                REG_DELAY: n.rdata = DATA_W'(r.cfg.delay);
                REG_DWIDTH: n.rdata = DATA_W'(r.cfg.dwidth);
                REG_DDELAY: n.rdata = DATA_W'(r.cfg.ddelay);
                REG_STATUS: n.rdata = DATA_W'({r.tr_idx, r.second, r.pulse, r.st});
                REG_TR_SEL: n.rdata = DATA_W'(r.tr_sel);
                REG_TR_ON: n.rdata = DATA_W'(tr_on[r.tr_sel]);
                REG_TR_OFF: n.rdata = DATA_W'(tr_off[r.tr_sel]);
                REG_TR_REP: n.rdata = DATA_W'(tr_rp[r.tr_sel]);
                REG_TR_LEN: n.rdata = DATA_W'(r.tr_len);
                default: n.rdata = '0;
            endcase
        end

        if (r.sync_cnt != 2'h0)
        begin
            n.sync_cnt = r.sync_cnt - 2'h1;
        end
        if (r.per_cnt != '0)
        begin
            n.per_cnt = r.per_cnt - CNT_W'(1);
        end
        if (r.ph_cnt != '0)
        begin
            n.ph_cnt = r.ph_cnt - CNT_W'(1);
        end

        // Second pulse timer runs from first pulse start, through on and off alike
        if (pm == PM_DOUBLE && !r.second && r.lat_cnt != '0 && (r.st == ST_ON || r.st == ST_OFF))
        begin
            n.lat_cnt = r.lat_cnt - CNT_W'(1);
        end

        case (r.st)
            ST_IDLE: n.pulse = 1'b0;
            ST_LAT:
            begin
                n.lat_cnt = r.lat_cnt - CNT_W'(1);
                if (r.lat_cnt == CNT_W'(1))
                begin
                    n.sync_lvl = 1'b1;
                    n.sync_cnt = 2'(SYNC_CYC);
                    if (pm == PM_DOUBLE || pm == PM_TRAIN || r.act.delay == '0)
                    begin
                        n.st = ST_ON;
                        n.pulse = 1'b1;
                        n.per_cnt = r.act.period;
                        n.ph_cnt = (pm == PM_TRAIN) ? tr_on[r.tr_idx] : r.act.width;
                        n.lat_cnt = r.act.ddelay;
                    end
                    else
                    begin
                        n.st = ST_DELAY;
                        n.ph_cnt = r.act.delay;
                    end
                end
            end
            ST_DELAY:
            begin
                if (r.ph_cnt == CNT_W'(1))
                begin
                    n.st = ST_ON;
                    n.pulse = 1'b1;
                    n.per_cnt = r.act.period;
                    n.ph_cnt = r.act.width;
                end
            end
            ST_ON:
            begin
                if (r.ph_cnt <= CNT_W'(1))
                begin
                    n.st = ST_OFF;
                    n.pulse = 1'b0;
                    n.ph_cnt = (pm == PM_TRAIN) ? tr_off[r.tr_idx] : '0;
                end
            end
            ST_OFF:
            begin
                if (pm == PM_DOUBLE && !r.second && r.lat_cnt <= CNT_W'(1))
                begin
                    n.st = ST_ON;
                    n.second = 1'b1;
                    n.pulse = 1'b1;
                    n.ph_cnt = r.act.dwidth;
                end
                else if (pm == PM_TRAIN && r.ph_cnt <= CNT_W'(1))
                begin
                    // Skip zero count entries when moving on
                    if (r.tr_rep > REP_W'(1))
                    begin
                        n.tr_rep = r.tr_rep - REP_W'(1);
                        n.st = ST_ON;
                        n.pulse = 1'b1;
                        n.ph_cnt = tr_on[r.tr_idx];
                    end
                    else
                    begin
                        n.st = ST_IDLE;
                        n.tr_idx = r.tr_idx + TRAIN_AW'(1);
                        n.tr_rep = '0;
                    end
                end
                else if (pm != PM_TRAIN && r.per_cnt <= CNT_W'(1))
                begin
                    // Free-running periods restart here, so starts sit exactly one period apart
                    n.st = free_run ? ST_ON : ST_IDLE;
                    n.second = 1'b0;
                    n.pulse = free_run;
                    n.act = free_run ? r.cfg : r.act;
                    n.per_cnt = r.cfg.period;
                    n.ph_cnt = r.cfg.width;
                    n.lat_cnt = r.cfg.ddelay;
                    n.sync_lvl = free_run;
                    n.sync_cnt = 2'(SYNC_CYC);
                end
            end
            default: n.st = ST_IDLE;
        endcase

        // Train entries with zero count are stepped over one per cycle
        if (pm == PM_TRAIN && r.st == ST_IDLE && r.tr_rep == '0)
        begin
            n.tr_idx = (r.tr_idx + TRAIN_AW'(1) >= r.tr_len[TRAIN_AW-1:0] && r.tr_len != '0)
                ? '0 : r.tr_idx + TRAIN_AW'(1);
            n.tr_rep = tr_rp[n.tr_idx];
        end
        else if (pm == PM_TRAIN && r.st == ST_IDLE
                 && {1'b0, r.tr_idx} >= r.tr_len)
        begin
            n.tr_idx = '0;
            n.tr_rep = tr_rp[0];
        end

        if (start && !(pm == PM_TRAIN && r.tr_rep == '0))
        begin
            n.st = ST_LAT;
            n.act = r.cfg;
            n.lat_cnt = CNT_W'(TRIG_LAT);
            n.second = 1'b0;
            n.pulse = 1'b0;
        end

        if (r.sync_cnt == 2'h1)
        begin
            n.sync_lvl = 1'b0;
        end
        // Seq-marking off: sync follows the ST_LAT state, high only during trigger latency
        n.pulse_oe = r.ctrl[F_OUTEN];
    end

    always_ff @(posedge clk_i)
    begin
        if (req.wr && req.addr == REG_TR_ON)
        begin
            tr_on[r.tr_sel] <= req.wdata[CNT_W-1:0];
        end
        if (req.wr && req.addr == REG_TR_OFF)
        begin
            tr_off[r.tr_sel] <= req.wdata[CNT_W-1:0];
        end
        if (req.wr && req.addr == REG_TR_REP)
        begin
            tr_rp[r.tr_sel] <= req.wdata[REP_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.ctrl <= CTRL_RESET;
            r.tr_len <= (TRAIN_AW+1)'(1);
        end
        else
        begin
            r <= n;
        end
    end

    // Output stage: gated and polarity-adjusted straight from flops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pulse_o <= 1'b0;
            pulse_oe_o <= 1'b0;
            sync_o <= 1'b0;
            rdata_o <= '0;
        end
        else
        begin
            pulse_o <= n.ctrl[F_OUTEN] & (n.pulse ^ n.ctrl[F_OPOL]);
            pulse_oe_o <= n.pulse_oe;
            sync_o <= n.ctrl[F_SYNCM] ? n.sync_lvl : (n.st == ST_LAT);
            rdata_o <= n.rdata;
        end
    end

    property p_pulse_gated;
        @(posedge clk_i) disable iff (!rst_n_i)
        !r.ctrl[F_OUTEN] |-> !pulse_o;
    endproperty
    a_pulse_gated: assert property (p_pulse_gated) else $error("pulse while disabled");

    property p_polarity;
        @(posedge clk_i) disable iff (!rst_n_i)
        r.ctrl[F_OUTEN] && n.ctrl[F_OUTEN] |=> pulse_o == (r.pulse ^ r.ctrl[F_OPOL]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong");

    property p_sync_before_pulse;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(r.pulse) && !r.second && r.tr_rep == $past(r.tr_rep) |-> r.sync_lvl || $past(r.st) == ST_DELAY
            || $past(r.st) == ST_LAT;
    endproperty
    a_sync_before_pulse: assert property (p_sync_before_pulse) else $error("no sync");

    property p_latency;
        @(posedge clk_i) disable iff (!rst_n_i)
        r.st == ST_IDLE ##1 r.st == ST_LAT |-> ##2 r.st != ST_IDLE;
    endproperty
    a_latency: assert property (p_latency) else $error("latency broken");

    property p_no_int_single_in_auto;
        @(posedge clk_i) disable iff (!rst_n_i)
        tm != TM_INT_SINGLE |=> !r.sw_trig;
    endproperty
    a_no_int_single_in_auto: assert property (p_no_int_single_in_auto) else $error("sw trig");

    property p_double_ignore;
        @(posedge clk_i) disable iff (!rst_n_i)
        pm == PM_DOUBLE && busy && r.st != ST_LAT |=> r.st != ST_LAT;
    endproperty
    a_double_ignore: assert property (p_double_ignore) else $error("double retriggered");

    property p_second_width;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(r.second) |-> r.ph_cnt == r.act.dwidth;
    endproperty
    a_second_width: assert property (p_second_width) else $error("second width");

    property p_act_stable;
        @(posedge clk_i) disable iff (!rst_n_i)
        r.st == ST_ON ##1 r.st != ST_LAT |-> $stable(r.act);
    endproperty
    a_act_stable: assert property (p_act_stable) else $error("timing changed mid pulse");

    c_double: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(r.second));
    c_train: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        pm == PM_TRAIN && $rose(r.pulse));
    c_gated: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        tm == TM_EXT_GATED && $rose(r.pulse));
endmodule
`default_nettype wire

// ---- tb/test_pulse_mod_function.sv ----
// Purpose: Self-checking bench for the pulse modulation generator
// Assumes: 40 MHz clock, register port driven by tasks
// Notes: Pulse times come from the far-side model in whole cycles
`default_nettype none
module test_pulse_mod_function
    import pulse_gen_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic act_hi;
    logic ext_trig;
    logic [DATA_W-1:0] rdata_o;
    logic pulse_o;
    logic pulse_oe_o;
    logic sync_o;
    logic [DATA_W-1:0] v;
    int fail_count = 0;
    int checked = 0;
    int s0;
    int n1;

    always #12.5 clk_i = ~clk_i;

    pulse_mod_function #(.DEPTH(TRAIN_DEPTH)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .ext_trig_i(ext_trig),
        .rdata_o(rdata_o), .pulse_o(pulse_o), .pulse_oe_o(pulse_oe_o), .sync_o(sync_o));

    trigger_source_model model (.clk_i(clk_i), .pulse_i(pulse_o), .sync_i(sync_o),
        .act_hi_i(act_hi), .trig_o(ext_trig));

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [31:0] ctl(input pmode_t m, input tmode_t t, input logic oen,
        input logic opol, input logic sm);
        ctl = 32'h0000_0000;
        ctl[F_MODE +: 2] = m;
        ctl[F_TRIG +: 3] = t;
        ctl[F_OUTEN] = oen;
        ctl[F_OPOL] = opol;
        ctl[F_SYNCM] = sm;
        ctl[F_RUN] = 1'b1;
    endfunction
    // Width stays at least one cycle (25 ns) under the period
    task automatic tim(input int p, input int w, input int d, input int dw, input int dd);
        wr(REG_PERIOD, p);
        wr(REG_WIDTH, w);
        wr(REG_DELAY, d);
        wr(REG_DWIDTH, dw);
        wr(REG_DDELAY, dd);
    endtask
    task automatic gaps(input string name, input int g, input int w);
        for (int i = 1; i < model.widths.size(); i++)
        begin
            check(name, g, model.starts[i] - model.starts[i-1]);
            check(name, w, model.widths[i]);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        results();
    end

    initial
    begin
        rst_n_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        act_hi = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(REG_CTRL, v);
        check("ctrl reset", CTRL_RESET, v);
        rd(REG_TR_LEN, v);
        check("train length reset", 32'h0000_0001, v);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, v);
        check("unmapped read", 32'h0000_0000, v);
        tim(20, 5, 3, 0, 0);
        rd(REG_PERIOD, v);
        check("period readback", 32'h0000_0014, v);
        $display("register test done");
        wr(REG_CTRL, ctl(PM_SINGLE, TM_AUTO, 1'b1, 1'b0, 1'b0));
        repeat (40) @(posedge clk_i);
        model.clear();
        repeat (200) @(posedge clk_i);
        check("auto count", 10, model.starts.size());
        gaps("auto period and width", 20, 5);
        check("output enable", 1'b1, pulse_oe_o);
        act_hi <= 1'b0;
        wr(REG_CTRL, ctl(PM_SINGLE, TM_AUTO, 1'b1, 1'b1, 1'b0));
        repeat (40) @(posedge clk_i);
        model.clear();
        repeat (200) @(posedge clk_i);
        check("inverted count", 10, model.starts.size());
        gaps("inverted period and width", 20, 5);
        wr(REG_CTRL, ctl(PM_SINGLE, TM_AUTO, 1'b0, 1'b0, 1'b0));
        act_hi <= 1'b1;
        repeat (10) @(posedge clk_i);
        model.clear();
        repeat (100) @(posedge clk_i);
        check("disabled count", 0, model.starts.size());
        check("disabled level", 1'b0, pulse_o);
        check("disabled enable", 1'b0, pulse_oe_o);
        $display("auto test done");
        tim(200, 5, 0, 6, 12);
        wr(REG_CTRL, ctl(PM_SINGLE, TM_INT_SINGLE, 1'b1, 1'b0, 1'b0));
        // A long free-running period left from the auto test must run out first
        repeat (200) @(posedge clk_i);
        model.clear();
        repeat (100) @(posedge clk_i);
        check("no trigger yet", 0, model.starts.size());
        wr(REG_CMD, CMD_TRIG_BIT);
        repeat (250) @(posedge clk_i);
        check("one shot count", 1, model.starts.size());
        s0 = model.starts[0] - model.syncs[0];
        check("sync ahead of pulse", 1'b1, s0 > 0);
        wr(REG_DELAY, 7);
        model.clear();
        wr(REG_CMD, CMD_TRIG_BIT);
        repeat (250) @(posedge clk_i);
        check("pulse delay", s0 + 7, model.starts[0] - model.syncs[0]);
        wr(REG_CTRL, ctl(PM_DOUBLE, TM_INT_SINGLE, 1'b1, 1'b0, 1'b0));
        model.clear();
        wr(REG_CMD, CMD_TRIG_BIT);
        repeat (250) @(posedge clk_i);
        check("double count", 2, model.starts.size());
        check("double no delay", s0, model.starts[0] - model.syncs[0]);
        check("double gap", 12, model.starts[1] - model.starts[0]);
        check("first width", 5, model.widths[0]);
        check("second width", 6, model.widths[1]);
        $display("internal trigger test done");
        wr(REG_CTRL, ctl(PM_SINGLE, TM_EXT_SINGLE, 1'b1, 1'b0, 1'b0));
        model.clear();
        wr(REG_CMD, CMD_TRIG_BIT);
        repeat (100) @(posedge clk_i);
        check("command refused", 0, model.starts.size());
        model.fire(10);
        repeat (250) @(posedge clk_i);
        check("external single", 1, model.starts.size());
        wr(REG_DELAY, 0);
        // Inverted input polarity: the falling trigger edge starts a sequence, and so does setting the bit while the input is low
        wr(REG_CTRL, ctl(PM_SINGLE, TM_EXT_SINGLE, 1'b1, 1'b0, 1'b0) | (32'h1 << F_TPOL));
        repeat (250) @(posedge clk_i);
        model.clear();
        model.fire(10);
        check("inverted trigger early", 0, model.starts.size());
        repeat (250) @(posedge clk_i);
        check("inverted trigger", 1, model.starts.size());
        wr(REG_CTRL, ctl(PM_SINGLE, TM_EXT_RETRIG, 1'b1, 1'b0, 1'b0));
        model.clear();
        model.fire(3);
        repeat (11) @(posedge clk_i);
        model.fire(3);
        repeat (250) @(posedge clk_i);
        check("restart gap", 15, model.starts[1] - model.starts[0]);
        wr(REG_CTRL, ctl(PM_DOUBLE, TM_EXT_RETRIG, 1'b1, 1'b0, 1'b0));
        repeat (10) @(posedge clk_i);
        model.clear();
        model.fire(3);
        repeat (4) @(posedge clk_i);
        model.fire(3);
        repeat (150) @(posedge clk_i);
        check("busy count", 2, model.starts.size());
        check("busy gap", 12, model.starts[1] - model.starts[0]);
        $display("external trigger test done");
        tim(20, 5, 3, 6, 12);
        wr(REG_CTRL, ctl(PM_SINGLE, TM_EXT_GATED, 1'b1, 1'b0, 1'b0));
        repeat (250) @(posedge clk_i);
        model.clear();
        model.fire(100);
        repeat (30) @(posedge clk_i);
        n1 = model.starts.size();
        check("gated running", 1'b1, n1 > 3);
        gaps("gated period and width", 20, 5);
        repeat (100) @(posedge clk_i);
        check("gate closed", n1, model.starts.size());
        $display("gated test done");
        wr(REG_TR_SEL, 0);
        wr(REG_TR_ON, 4);
        wr(REG_TR_OFF, 4);
        wr(REG_TR_REP, 0);
        wr(REG_TR_SEL, 1);
        wr(REG_TR_ON, 3);
        wr(REG_TR_OFF, 5);
        wr(REG_TR_REP, 3);
        wr(REG_TR_LEN, 2);
        wr(REG_CTRL, ctl(PM_TRAIN, TM_INT_SINGLE, 1'b1, 1'b0, 1'b1));
        repeat (10) @(posedge clk_i);
        model.clear();
        wr(REG_CMD, CMD_TRIG_BIT);
        repeat (150) @(posedge clk_i);
        check("train count", 3, model.starts.size());
        gaps("train on and off", 8, 3);
        check("sync marks", 1, model.syncs.size());
        check("sync width", SYNC_CYC, model.sync_w[0]);
        wr(REG_CMD, CMD_TRIG_BIT);
        repeat (150) @(posedge clk_i);
        check("train wrap", 6, model.starts.size());
        check("sync marks again", 2, model.syncs.size());
        $display("train test done");
        results();
    end
endmodule
`default_nettype wire

// ---- tb/trigger_source_model.sv ----
// Purpose: Far-side model, trigger or gate source plus a pulse-watching modulator
// Assumes: The bench drives the trigger through the fire task
// Notes: Edge times are whole generator clock cycles
`default_nettype none
module trigger_source_model (
    input wire logic clk_i,
    input wire logic pulse_i,
    input wire logic sync_i,
    input wire logic act_hi_i,
    output logic trig_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0;
    int p_t0 = 0;
    int s_t0 = 0;
    int starts[$];
    int widths[$];
    int syncs[$];
    int sync_w[$];
    logic p_q = 1'b0;
    logic s_q = 1'b0;
    logic act;
    initial trig_o = 1'b0;
    assign act = act_hi_i ? pulse_i : ~pulse_i;
    // Widths pair with starts only, so a fall seen right after clear is dropped
    // Falling-edge sampling keeps the counts clear of the bench's rising-edge steps
    always @(negedge clk_i)
    begin
        cyc++;
        if (act && !p_q)
        begin
            starts.push_back(cyc);
            p_t0 = cyc;
        end
        if (!act && p_q && starts.size() > widths.size())
            widths.push_back(cyc - p_t0);
        if (sync_i && !s_q)
        begin
            syncs.push_back(cyc);
            s_t0 = cyc;
        end
        if (!sync_i && s_q && syncs.size() > sync_w.size())
            sync_w.push_back(cyc - s_t0);
        p_q = act;
        s_q = sync_i;
    end
    task automatic clear();
        starts.delete();
        widths.delete();
        syncs.delete();
        sync_w.delete();
    endtask
    // Rising edge is the event; a long high time doubles as a gate
    task automatic fire(input int hi);
        @(posedge clk_i);
        trig_o <= 1'b1;
        repeat (hi) @(posedge clk_i);
        trig_o <= 1'b0;
    endtask
endmodule
`default_nettype wire
